/* rtl/bit_op_instruction_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_op_instruction_unit
  import bit_op_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic [INSTR_W-1:0]  instr_in,
  input  wire logic [DATA_W-1:0]   rd_data_in,
  output var  logic [1:0]          phase_out,
  output var  logic                rd_en_out,
  output var  logic [ADDR_W-1:0]   rd_addr_out,
  output var  logic                wr_en_out,
  output var  logic [ADDR_W-1:0]   wr_addr_out,
  output var  logic [DATA_W-1:0]   wr_data_out,
  output var  logic [1:0]          op_kind_out,
  output var  logic                discard_out,
  output var  logic                skip_pending_out,
  output var  logic                cycle_end_out,
  output var  logic                status_wr_en_out,
  output var  logic [STATUS_W-1:0] status_wr_mask_out
);

  // Classifies an instruction word by its top four bits.
  function automatic op_kind_t decode_kind(input logic [INSTR_W-1:0] word);
    logic [OPC_W-1:0] opc;
    opc = word[OPC_MSB:OPC_LSB];
    if (opc == OPC_CLEAR)
    begin
      decode_kind = bit_clear_op;
    end
    else if (opc == OPC_SET)
    begin
      decode_kind = bit_set_op;
    end
    else if (opc == OPC_TEST)
    begin
      decode_kind = bit_test_skip_clear_op;
    end
    else
    begin
      decode_kind = op_other;
    end
  endfunction

  // True for the two kinds that write the register back.
  function automatic logic is_modify(input op_kind_t kind);
    is_modify = (kind == bit_clear_op) || (kind == bit_set_op);
  endfunction

  phase_t phase;

  bit_op_phase_counter u_phase
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .phase_out  (phase)
  );

  op_kind_t              kind_r;
  op_kind_t              kind_nxt;
  logic [BITSEL_W-1:0]   bitsel_r;
  logic [BITSEL_W-1:0]   bitsel_nxt;
  logic [ADDR_W-1:0]     addr_r;
  logic [ADDR_W-1:0]     addr_nxt;
  logic                  rd_en_r;
  logic                  rd_en_nxt;
  logic [DATA_W-1:0]     data_r;
  logic [DATA_W-1:0]     data_nxt;
  logic [DATA_W-1:0]     result_r;
  logic [DATA_W-1:0]     result_nxt;
  logic                  wr_en_r;
  logic                  wr_en_nxt;
  logic                  skip_pending_r;
  logic                  skip_pending_nxt;
  logic                  discard_r;
  logic                  discard_nxt;
  logic [DATA_W-1:0]     modified;
  logic                  tested_bit;
  logic                  new_bit;

  assign new_bit    = (kind_r == bit_set_op);
  assign tested_bit = data_r[bitsel_r];

  // Only the selected bit takes the new value; the rest pass through.
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_bit
      assign modified[gi] = (bitsel_r == BITSEL_W'(gi)) ? new_bit : data_r[gi];
    end
  endgenerate

  always_comb
  begin
    kind_nxt         = kind_r;
    bitsel_nxt       = bitsel_r;
    addr_nxt         = addr_r;
    rd_en_nxt        = 1'b0;
    skip_pending_nxt = skip_pending_r;
    discard_nxt      = discard_r;
    unique case (phase)
      PH_DECODE:
      begin
        // A skip raised in the previous cycle turns the fetched word into a
        // no-operation, so all four phases of this cycle do nothing.
        if (skip_pending_r)
        begin
          kind_nxt         = op_other;
          discard_nxt      = 1'b1;
          skip_pending_nxt = 1'b0;
        end
        else
        begin
          kind_nxt    = decode_kind(instr_in);
          discard_nxt = 1'b0;
        end
        bitsel_nxt = instr_in[BITSEL_MSB:BITSEL_LSB];
        addr_nxt   = instr_in[ADDR_MSB:ADDR_LSB];
        rd_en_nxt  = !skip_pending_r && (decode_kind(instr_in) != op_other);
      end
      PH_PROCESS:
      begin
        // A one in the tested bit leaves the flow alone; only a zero skips.
        if ((kind_r == bit_test_skip_clear_op) && !tested_bit)
        begin
          skip_pending_nxt = 1'b1;
        end
        else
        begin
          skip_pending_nxt = skip_pending_r;
        end
      end
      PH_READ,
      PH_WRITE:
      begin
        discard_nxt = discard_r;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      kind_r         <= op_other;
      bitsel_r       <= BITSEL_RST;
      addr_r         <= ADDR_RST;
      rd_en_r        <= 1'b0;
      skip_pending_r <= 1'b0;
      discard_r      <= 1'b0;
    end
    else
    begin
      kind_r         <= kind_nxt;
      bitsel_r       <= bitsel_nxt;
      addr_r         <= addr_nxt;
      rd_en_r        <= rd_en_nxt;
      skip_pending_r <= skip_pending_nxt;
      discard_r      <= discard_nxt;
    end
  end

  // Reading, modifying and writing back form their own group, apart from
  // the decode bookkeeping, so each step can be timed against the phase alone.
  always_comb
  begin
    data_nxt   = data_r;
    result_nxt = result_r;
    wr_en_nxt  = 1'b0;
    unique case (phase)
      PH_DECODE:
      begin
        result_nxt = result_r;
      end
      PH_READ:
      begin
        if (kind_r != op_other)
        begin
          data_nxt = rd_data_in;
        end
      end
      PH_PROCESS:
      begin
        result_nxt = modified;
        wr_en_nxt  = is_modify(kind_r);
      end
      PH_WRITE:
      begin
        wr_en_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      data_r   <= DATA_RST;
      result_r <= DATA_RST;
      wr_en_r  <= 1'b0;
    end
    else
    begin
      data_r   <= data_nxt;
      result_r <= result_nxt;
      wr_en_r  <= wr_en_nxt;
    end
  end

  assign phase_out        = phase;
  assign rd_en_out        = rd_en_r;
  assign rd_addr_out      = addr_r;
  assign wr_en_out        = wr_en_r;
  assign wr_addr_out      = addr_r;
  assign wr_data_out      = result_r;
  assign op_kind_out      = kind_r;
  assign discard_out      = discard_r;
  assign skip_pending_out = skip_pending_r;
  assign cycle_end_out    = (phase == PH_WRITE);

  // The status port exists so the core can merge writers; these
  // instructions never drive it, whatever the outcome.
  assign status_wr_en_out   = 1'b0;
  assign status_wr_mask_out = STATUS_NONE;

endmodule
`default_nettype wire

/* rtl/bit_op_pkg.sv */
`default_nettype none
package bit_op_pkg;

  localparam int INSTR_W   = 14;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 7;
  localparam int BITSEL_W  = 3;
  localparam int OPC_W     = 4;
  localparam int STATUS_W  = 8;

  localparam int OPC_MSB    = 13;
  localparam int OPC_LSB    = 10;
  localparam int BITSEL_MSB = 9;
  localparam int BITSEL_LSB = 7;
  localparam int ADDR_MSB   = 6;
  localparam int ADDR_LSB   = 0;

  localparam logic [OPC_W-1:0] OPC_CLEAR = 4'h4;
  localparam logic [OPC_W-1:0] OPC_SET   = 4'h5;
  localparam logic [OPC_W-1:0] OPC_TEST  = 4'h6;

  localparam logic [INSTR_W-1:0]  INSTR_RST  = 14'h0000;
  localparam logic [DATA_W-1:0]   DATA_RST   = 8'h00;
  localparam logic [ADDR_W-1:0]   ADDR_RST   = 7'h00;
  localparam logic [BITSEL_W-1:0] BITSEL_RST = 3'h0;
  localparam logic [STATUS_W-1:0] STATUS_NONE = 8'h00;

  typedef enum logic [1:0]
  {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

  typedef enum logic [1:0]
  {
    op_other               = 2'b00,
    bit_clear_op           = 2'b01,
    bit_set_op             = 2'b10,
    bit_test_skip_clear_op = 2'b11
  } op_kind_t;

endpackage
`default_nettype wire

/* rtl/bit_op_phase_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_op_phase_counter
  import bit_op_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  output var phase_t  phase_out
);

  phase_t phase_r;
  phase_t phase_nxt;

  // The four phases repeat without pause; each phase is one clock.
  always_comb
  begin
    unique case (phase_r)
      PH_DECODE:  phase_nxt = PH_READ;
      PH_READ:    phase_nxt = PH_PROCESS;
      PH_PROCESS: phase_nxt = PH_WRITE;
      PH_WRITE:   phase_nxt = PH_DECODE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      phase_r <= PH_DECODE;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  assign phase_out = phase_r;

endmodule
`default_nettype wire

/* verification/bit_op_instruction_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_op_checker
  import bit_op_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0]  rd_data_in,
  input wire logic [1:0]  phase_out,
  input wire logic        rd_en_out,
  input wire logic        wr_en_out,
  input wire logic [7:0]  wr_data_out,
  input wire logic [1:0]  op_kind_out,
  input wire logic        discard_out,
  input wire logic        skip_pending_out,
  input wire logic        status_wr_en_out,
  input wire logic [7:0]  status_wr_mask_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_clear_result:
    assert property (wr_en_out && op_kind_out == 2'h1 |-> wr_data_out ==
      ($past(rd_data_in, 2) & ~(8'h01 << $past(instr_in[9:7], 3)))) else $error("clear bad");
  a_set_result:
    assert property (wr_en_out && op_kind_out == 2'h2 |-> wr_data_out ==
      ($past(rd_data_in, 2) | (8'h01 << $past(instr_in[9:7], 3)))) else $error("set bad");
  a_test_pass:
    assert property (phase_out == 2'h1 && op_kind_out == 2'h3 && rd_data_in[$past(instr_in[9:7])]
      |-> ##2 !skip_pending_out ##2 !discard_out) else $error("false skip");
  a_test_skip:
    assert property (phase_out == 2'h1 && op_kind_out == 2'h3 && !rd_data_in[$past(instr_in[9:7])]
      |-> ##2 skip_pending_out ##2 (discard_out && op_kind_out == 2'h0 && !rd_en_out)
      ##2 !wr_en_out) else $error("skip missed");
  a_skip_span:
    assert property ($rose(discard_out) |-> discard_out [*4] ##1 !discard_out)
      else $error("skip length bad");
  a_phase_walk:
    assert property (rd_en_out |-> phase_out == 2'h1 ##2 (phase_out == 2'h3 &&
      wr_en_out == (op_kind_out != 2'h3))) else $error("phase order bad");
  a_kind_decode:
    assert property (phase_out == 2'h0 && !skip_pending_out && instr_in[13:10] inside
      {4'h4, 4'h5, 4'h6} |=> op_kind_out == $past(instr_in[11:10]) + 2'h1 && rd_en_out)
      else $error("decode bad");
  a_no_status:
    assert property (!status_wr_en_out && status_wr_mask_out == 8'h00) else $error("flag write");
endmodule
bind bit_op_instruction_unit bit_op_checker chk (.clk_in, .sys_rst_in, .instr_in, .rd_data_in,
  .phase_out, .rd_en_out, .wr_en_out, .wr_data_out, .op_kind_out, .discard_out,
  .skip_pending_out, .status_wr_en_out, .status_wr_mask_out);
`default_nettype wire

/* verification/bit_op_instruction_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_op_instruction_unit_tb_top
  import bit_op_pkg::*;
();
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [13:0] instr_in = 14'h0000;
  logic [7:0]  rd_data_in = 8'h00;
  logic [1:0]  phase_out, op_kind_out;
  logic [6:0]  rd_addr_out, wr_addr_out;
  logic [7:0]  wr_data_out, status_wr_mask_out;
  logic        rd_en_out, wr_en_out, discard_out, skip_pending_out, cycle_end_out;
  logic        status_wr_en_out, dsc;
  logic [7:0]  mem [128];
  int          mismatches = 0;
  int          cmp_count = 0;
  bit_op_instruction_unit dut (.clk_in, .sys_rst_in, .instr_in, .rd_data_in, .phase_out,
    .rd_en_out, .rd_addr_out, .wr_en_out, .wr_addr_out, .wr_data_out, .op_kind_out,
    .discard_out, .skip_pending_out, .cycle_end_out, .status_wr_en_out, .status_wr_mask_out);
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  // The register file answers on the falling edge so the read data is settled for the READ edge.
  always @(negedge clk_in) rd_data_in <= mem[rd_addr_out];
  always @(posedge clk_in)
  begin
    if (wr_en_out === 1'b1) mem[wr_addr_out] <= wr_data_out;
  end
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // One word per four clocks; the discard flag is sampled mid-cycle, once it is settled.
  task automatic exec(input logic [13:0] w);
    instr_in = w;
    repeat (2) @(negedge clk_in);
    dsc = discard_out;
    check("cycle end early", {7'h00, cycle_end_out}, 8'h00);
    @(negedge clk_in);
    check("cycle end", {7'h00, cycle_end_out}, 8'h01);
    @(negedge clk_in);
  endtask
  task automatic t_clear_set();
    for (int b = 0; b < 8; b++)
    begin
      mem[7'h15] = 8'hC7;
      mem[7'h16] = 8'h0A;
      exec({OPC_CLEAR, b[2:0], 7'h15});
      exec({OPC_SET, b[2:0], 7'h16});
      check("clear", mem[7'h15], 8'hC7 & ~(8'h01 << b));
      check("set", mem[7'h16], 8'h0A | (8'h01 << b));
    end
  endtask
  task automatic t_skip();
    mem[7'h20] = 8'h02;
    exec({OPC_TEST, 3'h1, 7'h20});
    exec({OPC_SET, 3'h0, 7'h30});
    check("no skip", mem[7'h30], 8'h01);
    check("no discard", {7'h00, dsc}, 8'h00);
    exec({OPC_TEST, 3'h2, 7'h20});
    exec({OPC_CLEAR, 3'h1, 7'h20});
    check("discard", {7'h00, dsc}, 8'h01);
    check("skipped", mem[7'h20], 8'h02);
    exec({OPC_SET, 3'h2, 7'h30});
    check("after skip", mem[7'h30], 8'h05);
    check("status mask", status_wr_mask_out, 8'h00);
    check("status en", {7'h00, status_wr_en_out}, 8'h00);
  endtask
  // A word outside the three bit opcodes must neither read nor write the register.
  task automatic t_other();
    mem[7'h40] = 8'h5A;
    exec({4'h0, 3'h3, 7'h40});
    check("other kind", {6'h00, op_kind_out}, 8'h00);
    check("other", mem[7'h40], 8'h5A);
    check("other no discard", {7'h00, dsc}, 8'h00);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_clear_set();
    t_skip();
    t_other();
    give_verdict();
  end
  initial
  begin
    #20000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
